// *** timer_pkg.sv ***
`default_nettype none
package timer_pkg;
    // ****************************************************************
    // widths and counter limits
    // ****************************************************************
    localparam int unsigned COUNT_W = 12;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned DUTY_HIGH_W = 4;
    localparam logic [11:0] COUNT_MAX = 12'hFFF;
    localparam logic [11:0] COUNT_ONE = 12'h001;
    localparam logic [11:0] COUNT_RESET = 12'h000;
    localparam logic [11:0] DUTY_OFF = 12'h000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // slow mode divides the counter input by 32
    localparam logic [4:0] PRESCALE_LAST = 5'h1F;
    localparam logic [4:0] PRESCALE_ONE = 5'h01;
    localparam logic [4:0] PRESCALE_RESET = 5'h00;

    // ****************************************************************
    // register indices; byte address is four times the index
    // ****************************************************************
    localparam int unsigned ADDR_LSB = 2;
    localparam logic [7:0] IDX_CONTROL = 8'h0D;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h0E;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h0F;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'h10;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'h11;
    localparam logic [7:0] IDX_PIN_CONTROL = 8'h12;
    localparam logic [7:0] IDX_WAVE_STATUS = 8'h13;
    localparam logic [7:0] IDX_DUTY_HIGH = 8'h17;
    localparam logic [7:0] IDX_DUTY_LOW = 8'h18;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned CTRL_SRC_LSB = 3;
    localparam int unsigned CTRL_OVF_BIT = 2;
    localparam int unsigned CTRL_OVERFLOW_IRQ_ENABLE_BIT = 1;
    localparam int unsigned CTRL_COMPARE_IRQ_ENABLE_BIT = 0;
    localparam int unsigned STAT_INVERT_BIT = 1;
    localparam int unsigned STAT_CMPF_BIT = 0;
    localparam int unsigned PIN_ENABLE_BIT = 0;

    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_TICK = 2'h1;
    localparam logic [1:0] SRC_CPU = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] HRDATA_RESET = 32'h00000000;

    typedef struct packed {
        logic [1:0] count_source_select;
        logic overflow_irq_enable;
        logic compare_irq_enable;
    } control_t;

    typedef struct packed {
        logic slow;
        logic halt;
        logic active_halt;
    } power_mode_t;

    localparam control_t CONTROL_RESET = '{SRC_OFF, 1'b0, 1'b0};
endpackage
`default_nettype wire

// *** count_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module count_gate
    import timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire timer_pkg::control_t control,
    input wire timer_pkg::power_mode_t power_mode,
    input wire logic timebase_tick,
    output logic count_tick
);
    logic [4:0] prescale;
    logic [4:0] next_prescale;
    logic next_count_tick;
    logic source_pulse;
    logic running;

    always_comb
    begin
        // codes 00 and 11 give no source pulse at all
        case (control.count_source_select)
            SRC_TICK: source_pulse = timebase_tick;
            SRC_CPU: source_pulse = 1'b1;
            default: source_pulse = 1'b0;
        endcase
        // wait mode has no effect, so it is not even an input
        running = !power_mode.halt && (!power_mode.active_halt ||
            (control.count_source_select == SRC_TICK && control.overflow_irq_enable));
        next_prescale = prescale;
        next_count_tick = 1'b0;
        if (!power_mode.slow)
        begin
            next_prescale = PRESCALE_RESET;
            next_count_tick = running && source_pulse;
        end
        else if (running && source_pulse)
        begin
            next_prescale = prescale + PRESCALE_ONE;
            next_count_tick = (prescale == PRESCALE_LAST);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prescale <= PRESCALE_RESET;
            count_tick <= 1'b0;
        end
        else
        begin
            prescale <= next_prescale;
            count_tick <= next_count_tick;
        end
    end
endmodule
`default_nettype wire

// *** compare_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module compare_unit
    import timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic count_tick,
    input wire logic overflow_now,
    input wire logic [11:0] up_count,
    input wire logic [11:0] duty_value,
    input wire logic compare_lock,
    input wire logic wave_pin_enable,
    output logic wave,
    output logic match
);
    logic [11:0] shadow;
    logic [11:0] next_shadow;
    logic next_wave;
    logic next_match;
    logic [11:0] compare_value;

    always_comb
    begin
        // both bytes copy even if the low byte is still pending
        next_shadow = overflow_now ? duty_value : shadow;
        // waveform mode uses the shadow, compare mode the direct value
        compare_value = wave_pin_enable ? next_shadow : duty_value;
        // up_count is the value the counter takes at this edge, so the
        // waveform falls together with the count and not one count late
        next_match = count_tick && !compare_lock && up_count == compare_value &&
            (wave_pin_enable || duty_value != DUTY_OFF);
        next_wave = wave;
        if (next_match && wave_pin_enable)
        begin
            // duty equal to reload gives a steady level, not a one-count spike
            next_wave = 1'b0;
        end
        else if (overflow_now)
        begin
            next_wave = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shadow <= DUTY_OFF;
            wave <= 1'b0;
            match <= 1'b0;
        end
        else
        begin
            shadow <= next_shadow;
            wave <= next_wave;
            match <= next_match;
        end
    end
endmodule
`default_nettype wire

// *** autoreload_pwm_timer.sv ***
// Behaviour
// - 12-bit counter overflows after all-ones value
// - two-bit field selects off, timebase, cpu clock
// - overflow reloads counter from reload value
// - overflow loads shadow duty, waveform goes high
// - count equal shadow drives waveform low
// - polarity bit inverts the output pin
// - pin enable drives waveform onto pin
// - duty high write locks compare until low
// - compare mode uses written duty at once
// - compare match sets flag, maybe interrupt
// - no compare-mode matching while duty is zero
// - shadow copied every overflow; modes pick source
// - overflow sets flag; control read clears it
// - overflow flag lasts one counter clock
// - separate enabled overflow and compare requests
// - slow divides by 32; halt stops counter
// - active halt runs only timebase with irq
// - counter resets to zero, counts when selected
// - reading wave status clears compare flag
// - polarity resets to zero, one inverts
// - duty is 12 bits over two bytes
// - pin enable clear releases the pin
`timescale 1ns/1ps
`default_nettype none
module autoreload_pwm_timer
    import timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic timebase_tick,
    input wire timer_pkg::power_mode_t power_mode,
    output logic wave_output,
    output logic wave_output_enable,
    output logic overflow_irq,
    output logic compare_irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    control_t control;
    control_t next_control;
    logic [11:0] up_count;
    logic [11:0] next_up_count;
    logic [11:0] reload_value;
    logic [11:0] next_reload_value;
    logic [11:0] duty_value;
    logic [11:0] next_duty_value;
    logic compare_lock;
    logic next_compare_lock;
    logic wave_pin_enable;
    logic next_wave_pin_enable;
    logic wave_invert;
    logic next_wave_invert;
    logic overflow_flag;
    logic next_overflow_flag;
    logic compare_flag;
    logic next_compare_flag;
    logic next_wave_output;
    logic next_overflow_irq;
    logic next_compare_irq;
    logic wr_pending;
    logic next_wr_pending;
    logic rd_pending;
    logic next_rd_pending;
    logic [7:0] wr_index;
    logic [7:0] next_wr_index;
    logic [7:0] rd_index;
    logic [7:0] next_rd_index;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic [7:0] read_byte;
    logic accept;
    logic count_tick;
    logic overflow_now;
    logic wave;
    logic match;
    logic read_control;
    logic read_status;

    // ****************************************************************
    // clock source selection and compare path
    // ****************************************************************
    count_gate u_count_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .control(control),
        .power_mode(power_mode),
        .timebase_tick(timebase_tick),
        .count_tick(count_tick)
    );

    compare_unit u_compare_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .count_tick(count_tick),
        .overflow_now(overflow_now),
        .up_count(next_up_count),
        .duty_value(duty_value),
        .compare_lock(compare_lock),
        .wave_pin_enable(wave_pin_enable),
        .wave(wave),
        .match(match)
    );

    // ****************************************************************
    // bus slave: writes take no wait, reads take one wait state
    // ****************************************************************
    // the read wait lets a write just before it land before the data is sampled
    always_comb
    begin
        accept = hsel && htrans == HTRANS_NONSEQ && hready;
        next_wr_pending = accept && hwrite;
        next_rd_pending = accept && !hwrite;
        next_wr_index = accept ? haddr[ADDR_LSB +: BYTE_W] : wr_index;
        next_rd_index = accept ? haddr[ADDR_LSB +: BYTE_W] : rd_index;
        next_hreadyout = !(accept && !hwrite);
        read_control = rd_pending && rd_index == IDX_CONTROL;
        read_status = rd_pending && rd_index == IDX_WAVE_STATUS;
        read_byte = BYTE_ZERO;
        case (rd_index)
            IDX_CONTROL:
            begin
                read_byte[CTRL_SRC_LSB +: 2] = control.count_source_select;
                read_byte[CTRL_OVF_BIT] = overflow_flag;
                read_byte[CTRL_OVERFLOW_IRQ_ENABLE_BIT] = control.overflow_irq_enable;
                read_byte[CTRL_COMPARE_IRQ_ENABLE_BIT] = control.compare_irq_enable;
            end
            IDX_COUNT_HIGH: read_byte[DUTY_HIGH_W-1:0] = up_count[COUNT_W-1:BYTE_W];
            IDX_COUNT_LOW: read_byte = up_count[BYTE_W-1:0];
            IDX_RELOAD_HIGH: read_byte[DUTY_HIGH_W-1:0] = reload_value[COUNT_W-1:BYTE_W];
            IDX_RELOAD_LOW: read_byte = reload_value[BYTE_W-1:0];
            IDX_PIN_CONTROL: read_byte[PIN_ENABLE_BIT] = wave_pin_enable;
            IDX_WAVE_STATUS:
            begin
                read_byte[STAT_INVERT_BIT] = wave_invert;
                read_byte[STAT_CMPF_BIT] = compare_flag;
            end
            IDX_DUTY_HIGH: read_byte[DUTY_HIGH_W-1:0] = duty_value[COUNT_W-1:BYTE_W];
            IDX_DUTY_LOW: read_byte = duty_value[BYTE_W-1:0];
            default: read_byte = BYTE_ZERO;
        endcase
        next_hrdata = rd_pending ? {24'h000000, read_byte} : hrdata;
    end

    // ****************************************************************
    // software-written registers
    // ****************************************************************
    always_comb
    begin
        next_control = control;
        next_reload_value = reload_value;
        next_duty_value = duty_value;
        next_compare_lock = compare_lock;
        next_wave_pin_enable = wave_pin_enable;
        next_wave_invert = wave_invert;
        if (wr_pending)
        begin
            case (wr_index)
                IDX_CONTROL:
                begin
                    next_control.count_source_select = hwdata[CTRL_SRC_LSB +: 2];
                    next_control.overflow_irq_enable = hwdata[CTRL_OVERFLOW_IRQ_ENABLE_BIT];
                    next_control.compare_irq_enable = hwdata[CTRL_COMPARE_IRQ_ENABLE_BIT];
                end
                IDX_RELOAD_HIGH:
                    next_reload_value[COUNT_W-1:BYTE_W] = hwdata[DUTY_HIGH_W-1:0];
                IDX_RELOAD_LOW: next_reload_value[BYTE_W-1:0] = hwdata[BYTE_W-1:0];
                IDX_PIN_CONTROL: next_wave_pin_enable = hwdata[PIN_ENABLE_BIT];
                IDX_WAVE_STATUS: next_wave_invert = hwdata[STAT_INVERT_BIT];
                IDX_DUTY_HIGH:
                begin
                    next_duty_value[COUNT_W-1:BYTE_W] = hwdata[DUTY_HIGH_W-1:0];
                    next_compare_lock = 1'b1;
                end
                IDX_DUTY_LOW:
                begin
                    next_duty_value[BYTE_W-1:0] = hwdata[BYTE_W-1:0];
                    next_compare_lock = 1'b0;
                end
                default: next_compare_lock = compare_lock;
            endcase
        end
    end

    // ****************************************************************
    // counter, flags and outputs
    // ****************************************************************
    always_comb
    begin
        next_up_count = up_count;
        overflow_now = 1'b0;
        if (count_tick)
        begin
            if (up_count == COUNT_MAX)
            begin
                next_up_count = reload_value;
                overflow_now = 1'b1;
            end
            else
            begin
                next_up_count = up_count + COUNT_ONE;
            end
        end
        // set wins over every clear
        next_overflow_flag = overflow_flag;
        if (count_tick || read_control)
        begin
            next_overflow_flag = 1'b0;
        end
        if (overflow_now)
        begin
            next_overflow_flag = 1'b1;
        end
        next_compare_flag = compare_flag;
        if (read_status)
        begin
            next_compare_flag = 1'b0;
        end
        if (match)
        begin
            next_compare_flag = 1'b1;
        end
        next_overflow_irq = next_overflow_flag && next_control.overflow_irq_enable;
        next_compare_irq = next_compare_flag && next_control.compare_irq_enable;
        // pin value only matters while enabled; released it stays low
        next_wave_output = next_wave_pin_enable && (wave ^ next_wave_invert);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            control <= CONTROL_RESET;
            up_count <= COUNT_RESET;
            reload_value <= COUNT_RESET;
            duty_value <= DUTY_OFF;
            compare_lock <= 1'b0;
            wave_pin_enable <= 1'b0;
            wave_invert <= 1'b0;
            overflow_flag <= 1'b0;
            compare_flag <= 1'b0;
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            wr_index <= BYTE_ZERO;
            rd_index <= BYTE_ZERO;
            hreadyout <= 1'b1;
            hrdata <= HRDATA_RESET;
            hresp <= HRESP_OKAY;
            wave_output <= 1'b0;
            wave_output_enable <= 1'b0;
            overflow_irq <= 1'b0;
            compare_irq <= 1'b0;
        end
        else
        begin
            control <= next_control;
            up_count <= next_up_count;
            reload_value <= next_reload_value;
            duty_value <= next_duty_value;
            compare_lock <= next_compare_lock;
            wave_pin_enable <= next_wave_pin_enable;
            wave_invert <= next_wave_invert;
            overflow_flag <= next_overflow_flag;
            compare_flag <= next_compare_flag;
            wr_pending <= next_wr_pending;
            rd_pending <= next_rd_pending;
            wr_index <= next_wr_index;
            rd_index <= next_rd_index;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= HRESP_OKAY;
            wave_output <= next_wave_output;
            wave_output_enable <= next_wave_pin_enable;
            overflow_irq <= next_overflow_irq;
            compare_irq <= next_compare_irq;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_source_stopped;
        control.count_source_select == SRC_OFF ||
            control.count_source_select == SRC_RESERVED;
    endsequence

    sequence seq_cpu_running;
        control.count_source_select == SRC_CPU && !power_mode.slow &&
            !power_mode.halt && !power_mode.active_halt;
    endsequence

    sequence seq_duty_high_write;
        wr_pending && wr_index == IDX_DUTY_HIGH;
    endsequence

    a_count_reload: assert property (count_tick && up_count == COUNT_MAX |=>
        up_count == $past(reload_value) && overflow_flag)
        else $error("counter did not reload after overflow");

    a_count_step: assert property (count_tick && up_count != COUNT_MAX |=>
        up_count == 12'($past(up_count) + COUNT_ONE))
        else $error("counter did not step by one");

    a_count_hold: assert property (!count_tick |=> up_count == $past(up_count))
        else $error("counter moved without a tick");

    a_source_off: assert property (seq_source_stopped ##1 seq_source_stopped |->
        !count_tick)
        else $error("tick with counter clock off");

    a_cpu_source: assert property (seq_cpu_running ##1 seq_cpu_running |-> count_tick)
        else $error("cpu clock source gave no tick");

    a_halt_stop: assert property (power_mode.halt [*2] |-> !count_tick)
        else $error("counter ticked in halt");

    a_ovf_one_cycle: assert property (overflow_flag && count_tick && !overflow_now |=>
        !overflow_flag)
        else $error("overflow flag outlived one counter cycle");

    a_ovf_read_clear: assert property (read_control && !overflow_now |=>
        !overflow_flag ##1 hreadyout)
        else $error("control read did not clear overflow flag");

    a_ovf_irq_gate: assert property (overflow_irq ==
        (overflow_flag && control.overflow_irq_enable))
        else $error("overflow request not gated by its enable");

    a_cmp_irq_gate: assert property (compare_irq ==
        (compare_flag && control.compare_irq_enable))
        else $error("compare request not gated by its enable");

    a_cmp_read_clear: assert property (read_status && !match |=> !compare_flag)
        else $error("status read did not clear compare flag");

    a_duty_lock: assert property (seq_duty_high_write |=> compare_lock ##1 !match)
        else $error("duty high write did not lock compare");

    a_pin_release: assert property (!wave_pin_enable |-> !wave_output_enable)
        else $error("pin driven while released");

    a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule
`default_nettype wire

// *** autoreload_pwm_timer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module autoreload_pwm_timer_test;
    import timer_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, timebase_tick;
    logic wave_output, wave_output_enable, overflow_irq, compare_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    power_mode_t power_mode;
    logic [7:0] a, b;
    logic [7:0] regs [10] = '{IDX_CONTROL, IDX_COUNT_HIGH, IDX_COUNT_LOW, IDX_RELOAD_HIGH,
        IDX_RELOAD_LOW, IDX_PIN_CONTROL, IDX_WAVE_STATUS, IDX_DUTY_HIGH, IDX_DUTY_LOW, 8'h20};
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int tdiv = 0;
    int hi, per, n;

    // ****************************************************************
    // clock, tick source, design
    // ****************************************************************
    initial
    begin
        hclk = 1'h0;
        forever #10 hclk = ~hclk;
    end

    assign hready = hreadyout;

    // timebase pulse every fourth cycle keeps the slow tick tests short
    always @(posedge hclk)
    begin
        tdiv <= (tdiv + 1) % 4;
        timebase_tick <= (tdiv == 3);
    end

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fails++;
            summarize();
        end
    end

    autoreload_pwm_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .timebase_tick(timebase_tick), .power_mode(power_mode), .wave_output(wave_output),
        .wave_output_enable(wave_output_enable), .overflow_irq(overflow_irq),
        .compare_irq(compare_irq));

    // ****************************************************************
    // bus and measurement tasks
    // ****************************************************************
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd,
        output logic [7:0] rd);
        hsel <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata[7:0];
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(idx, 1'h1, wd, d);
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? overflow_irq : ((s == 1) ? wave_output : compare_irq);
    endfunction

    // bounded so a dead output shows up as a wrong count, not a hang
    task automatic wait_for(input int s, input logic v, inout int k);
        int j;
        j = 0;
        while (pick(s) !== v && j < 5000)
        begin
            @(posedge hclk);
            j++;
        end
        k += j;
    endtask

    task automatic meas(input int s);
        int d;
        d = 0;
        hi = 0;
        // the first period may still run under the old settings
        repeat (2)
        begin
            wait_for(s, 1'h0, d);
            wait_for(s, 1'h1, d);
        end
        wait_for(s, 1'h0, hi);
        per = hi;
        wait_for(s, 1'h1, per);
    endtask

    task automatic frozen(input logic still);
        bus(IDX_COUNT_LOW, 1'h0, BYTE_ZERO, a);
        repeat (20) @(posedge hclk);
        bus(IDX_COUNT_LOW, 1'h0, BYTE_ZERO, b);
        `CHK(a === b, still)
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        hresetn = 1'h0;
        hsel = 1'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        power_mode = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        foreach (regs[i])
        begin
            bus(regs[i], 1'h0, BYTE_ZERO, a);
            `CHK(a, BYTE_ZERO)
        end
        wr(IDX_RELOAD_HIGH, 8'h0F);
        wr(IDX_RELOAD_LOW, 8'hF0);
        wr(IDX_COUNT_LOW, 8'h55);
        wr(8'h20, 8'hFF);
        bus(IDX_RELOAD_HIGH, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h0F)
        bus(IDX_RELOAD_LOW, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'hF0)
        bus(IDX_COUNT_LOW, 1'h0, BYTE_ZERO, a);
        `CHK(a, BYTE_ZERO)
        bus(8'h20, 1'h0, BYTE_ZERO, a);
        `CHK(a, BYTE_ZERO)
        wr(IDX_CONTROL, 8'h18);
        frozen(1'h1);
        wr(IDX_CONTROL, 8'h12);
        frozen(1'h0);
        meas(0);
        `CHK(hi, 1)
        `CHK(per, 16)
        power_mode.slow <= 1'h1;
        meas(0);
        `CHK(hi, 32)
        `CHK(per, 512)
        power_mode.slow <= 1'h0;
        power_mode.halt <= 1'h1;
        frozen(1'h1);
        power_mode.halt <= 1'h0;
        power_mode.active_halt <= 1'h1;
        wr(IDX_CONTROL, 8'h0A);
        frozen(1'h0);
        wr(IDX_CONTROL, 8'h08);
        frozen(1'h1);
        power_mode.active_halt <= 1'h0;
        power_mode.slow <= 1'h1;
        wr(IDX_CONTROL, 8'h0A);
        n = 0;
        wait_for(0, 1'h1, n);
        bus(IDX_CONTROL, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h0E)
        `CHK(compare_irq, 1'h0)
        @(posedge hclk);
        `CHK(overflow_irq, 1'h0)
        bus(IDX_CONTROL, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h0A)
        power_mode.slow <= 1'h0;
        wr(IDX_CONTROL, 8'h10);
        wr(IDX_DUTY_HIGH, 8'h0F);
        wr(IDX_DUTY_LOW, 8'hF8);
        wr(IDX_PIN_CONTROL, 8'h01);
        @(posedge hclk);
        `CHK(wave_output_enable, 1'h1)
        meas(1);
        `CHK(hi, 8)
        `CHK(per, 16)
        wr(IDX_DUTY_HIGH, 8'h0F);
        wr(IDX_DUTY_LOW, 8'hF4);
        wr(IDX_WAVE_STATUS, 8'h02);
        meas(1);
        `CHK(hi, 12)
        wr(IDX_PIN_CONTROL, 8'h00);
        wr(IDX_WAVE_STATUS, 8'h00);
        repeat (2) @(posedge hclk);
        `CHK({wave_output_enable, wave_output}, 2'h0)
        wr(IDX_CONTROL, 8'h11);
        wr(IDX_DUTY_HIGH, 8'h0F);
        wr(IDX_DUTY_LOW, 8'hF8);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        wait_for(2, 1'h1, n);
        `CHK(compare_irq, 1'h1)
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h01)
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h00)
        wr(IDX_DUTY_HIGH, 8'h0F);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        repeat (40) @(posedge hclk);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h00)
        wr(IDX_DUTY_LOW, 8'hF8);
        repeat (40) @(posedge hclk);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h01)
        // reload zero so the count really passes through zero
        wr(IDX_RELOAD_HIGH, 8'h00);
        wr(IDX_RELOAD_LOW, 8'h00);
        wr(IDX_DUTY_HIGH, 8'h00);
        wr(IDX_DUTY_LOW, 8'h00);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        repeat (4200) @(posedge hclk);
        bus(IDX_WAVE_STATUS, 1'h0, BYTE_ZERO, a);
        `CHK(a, 8'h00)
        summarize();
    end
endmodule
`default_nettype wire
